// ==== rtl/aafx_decode.v ====
// Instruction decoder for the abs/add slice
// Assumes a 32-bit word with bit 0 as the most significant field bit
`timescale 1ns/1ps
`include "aafx_defines.vh"

module aafx_decode
(
  // Instruction
  input  wire [31:0] instr,
  input  wire        legacy_arch,
  // Decoded fields
  output wire        is_abs,
  output wire        is_add,
  output wire [4:0]  dest_reg,
  output wire [4:0]  src_a_reg,
  output wire [4:0]  src_b_reg,
  output wire        oe_flag,
  output wire        record_flag
);

  wire       pri_ok;
  wire [8:0] xop;

  // Bit numbering counts from the msb, so field N sits at vector 31-N
  assign pri_ok = instr[`AAFX_PRI_MSB:`AAFX_PRI_LSB] == `AAFX_PRIMARY_OP;
  assign xop         = instr[`AAFX_XOP_MSB:`AAFX_XOP_LSB];
  assign dest_reg    = instr[`AAFX_DST_MSB:`AAFX_DST_LSB];
  assign src_a_reg   = instr[`AAFX_SRCA_MSB:`AAFX_SRCA_LSB];
  assign src_b_reg   = instr[`AAFX_SRCB_MSB:`AAFX_SRCB_LSB];
  assign oe_flag     = instr[`AAFX_OE_BIT];
  assign record_flag = instr[`AAFX_RC_BIT];
  assign is_abs = pri_ok & (xop == `AAFX_XOP_ABS) & legacy_arch;
  assign is_add = pri_ok & (xop == `AAFX_XOP_ADD);

endmodule

// ==== rtl/aafx_defines.vh ====
// Constants for the abs/add fixed-point slice: instruction fields and codes
// Included by the decoder, the slice top and the testbench (the register file does not); definitions only
`ifndef AAFX_DEFINES_VH
`define AAFX_DEFINES_VH

`define AAFX_PRIMARY_OP   6'h1f
`define AAFX_XOP_ABS      9'h168
`define AAFX_XOP_ADD      9'h10a
`define AAFX_PRI_MSB      31
`define AAFX_PRI_LSB      26
`define AAFX_DST_MSB      25
`define AAFX_DST_LSB      21
`define AAFX_SRCA_MSB     20
`define AAFX_SRCA_LSB     16
`define AAFX_SRCB_MSB     15
`define AAFX_SRCB_LSB     11
`define AAFX_OE_BIT       10
`define AAFX_XOP_MSB      9
`define AAFX_XOP_LSB      1
`define AAFX_RC_BIT       0
`define AAFX_MOST_NEG     32'h80000000
`define AAFX_XER_RESET    3'h0
`define AAFX_CR0_RESET    4'h0
`define AAFX_STAT_WIDTH   3
`define AAFX_ST_ILLEGAL   0
`define AAFX_ST_OVF       1
`define AAFX_ST_ABSNEG    2

`endif

// ==== rtl/aafx_regfile.v ====
// Small general register file: 32 words, two read ports, one write port
// Read data are registered; one clock, asynchronous active-low reset
`timescale 1ns/1ps

module aafx_regfile
#(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW    = 5
)
(
  // Clock and reset
  input  wire             sys_clk,
  input  wire             nrst,
  // Write port
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  // Read ports
  input  wire [AW-1:0]    rd_addr_a,
  input  wire [AW-1:0]    rd_addr_b,
  output reg  [WIDTH-1:0] rd_data_a,
  output reg  [WIDTH-1:0] rd_data_b
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Storage has no reset; only the read registers do
  always @(posedge sys_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data_a <= {WIDTH{1'b0}};
      rd_data_b <= {WIDTH{1'b0}};
    end
    else
    begin
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
    end
  end

endmodule

// ==== rtl/aafx_unit.v ====
// Fixed-point slice executing absolute value and add on a general register
// file, updating exception bits and condition field 0.
// Assumes instructions arrive as one-cycle issue pulses, synchronous to
// sys_clk; software reaches status and control over a simple strobe port.
`timescale 1ns/1ps
`include "aafx_defines.vh"

// How it works
// - Abs writes magnitude of source a
// - Most negative stays; overflow set if enabled
// - Abs only decoded on legacy architecture
// - Add writes 32-bit sum of sources
// - Add never changes carry
// - Four forms from overflow-enable and record bits
// - Overflow-enable updates overflow, sticky summary
// - Record sets sign bits, copies summary
module aafx_unit
#(
  parameter WIDTH = 32
)
(
  // Clock and reset
  input  wire        sys_clk,
  input  wire        nrst,
  // Instruction issue
  input  wire        issue,
  input  wire [31:0] instr,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Results
  output reg         done,
  output reg         illegal,
  output reg  [4:0]  wb_reg,
  output reg  [31:0] wb_data,
  output reg         carry_flag,
  output reg         overflow_flag,
  output reg         summary_flag,
  output reg         neg_result,
  output reg         pos_result,
  output reg         zero_result,
  output reg         cr0_summary,
  output reg         irq
);

  localparam ADR_CTRL   = 4'h0;
  localparam ADR_XER    = 4'h1;
  localparam ADR_CR0    = 4'h2;
  localparam ADR_STATUS = 4'h3;
  localparam ADR_CLEAR  = 4'h4;
  localparam ADR_ENABLE = 4'h5;
  localparam ADR_RESULT = 4'h6;
  localparam ADR_GPR_IX = 4'h7;
  localparam ADR_GPR_DT = 4'h8;

  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_EXEC = 2'h2;

  localparam SW = `AAFX_STAT_WIDTH;

  reg  [1:0]       state;
  reg  [1:0]       next_state;
  reg              legacy_arch;
  reg  [31:0]      instr_q;
  reg  [4:0]       gpr_index;
  reg  [SW-1:0]    status;
  reg  [SW-1:0]    irq_enable;
  reg  [SW-1:0]    next_status;
  reg  [SW-1:0]    events;

  wire             is_abs;
  wire             is_add;
  wire [4:0]       dest_reg;
  wire [4:0]       src_a_reg;
  wire [4:0]       src_b_reg;
  wire             oe_flag;
  wire             record_flag;
  wire [WIDTH-1:0] opa;
  wire [WIDTH-1:0] opb;
  wire             is_abs_q;
  wire             is_add_q;
  wire [4:0]       dest_q;
  wire             oe_q;
  wire             rc_q;
  wire [4:0]       src_a_q;
  wire [4:0]       src_b_q;
  wire             exec_ok;
  wire             rf_wr;
  wire [4:0]       rf_waddr;
  wire [WIDTH-1:0] rf_wdata;
  wire [4:0]       rf_raddr_a;
  wire [4:0]       rf_raddr_b;

  reg  [WIDTH-1:0] result;
  reg              ovf;
  reg              next_so;

  // Magnitude of a two's complement word; the most negative maps to itself
  function [WIDTH-1:0] mag;
    input [WIDTH-1:0] v;
    begin
      mag = v[WIDTH-1] ? (~v + {{(WIDTH-1){1'b0}}, 1'b1}) : v;
    end
  endfunction

  // Signed overflow of an add: operands agree in sign, sum differs
  function add_ovf;
    input [WIDTH-1:0] a;
    input [WIDTH-1:0] b;
    input [WIDTH-1:0] s;
    begin
      add_ovf = (a[WIDTH-1] == b[WIDTH-1]) & (s[WIDTH-1] != a[WIDTH-1]);
    end
  endfunction

  aafx_decode u_dec_in
  (
    .instr       (instr),
    .legacy_arch (legacy_arch),
    .is_abs      (is_abs),
    .is_add      (is_add),
    .dest_reg    (dest_reg),
    .src_a_reg   (src_a_reg),
    .src_b_reg   (src_b_reg),
    .oe_flag     (oe_flag),
    .record_flag (record_flag)
  );

  // Second decode of the held word; the mode is re-checked at execute
  aafx_decode u_dec_q
  (
    .instr       (instr_q),
    .legacy_arch (legacy_arch),
    .is_abs      (is_abs_q),
    .is_add      (is_add_q),
    .dest_reg    (dest_q),
    .src_a_reg   (src_a_q),
    .src_b_reg   (src_b_q),
    .oe_flag     (oe_q),
    .record_flag (rc_q)
  );

  // Software writes through the data register only while idle
  assign exec_ok    = (state == ST_EXEC) & (is_abs_q | is_add_q);
  assign rf_wr = exec_ok |
                 (reg_wr & (reg_addr == ADR_GPR_DT) & (state == ST_IDLE));
  assign rf_waddr   = (state == ST_EXEC) ? dest_q : gpr_index;
  assign rf_wdata   = (state == ST_EXEC) ? result : reg_wdata;
  // Operands come from the held word after issue: the live bus moves on
  assign rf_raddr_a = (state != ST_IDLE) ? src_a_q :
                      issue              ? src_a_reg : gpr_index;
  assign rf_raddr_b = (state != ST_IDLE) ? src_b_q : src_b_reg;

  aafx_regfile #(.WIDTH(WIDTH)) u_rf
  (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .wr_en     (rf_wr),
    .wr_addr   (rf_waddr),
    .wr_data   (rf_wdata),
    .rd_addr_a (rf_raddr_a),
    .rd_addr_b (rf_raddr_b),
    .rd_data_a (opa),
    .rd_data_b (opb)
  );

  // Execute datapath
  always @*
  begin
    result  = opa + opb;
    ovf     = add_ovf(opa, opb, result);
    if (is_abs_q)
    begin
      result = mag(opa);
      ovf    = (opa == `AAFX_MOST_NEG);
    end
    next_so = summary_flag | (oe_q & ovf);
  end

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (issue && (is_abs || is_add))
          next_state = ST_READ;
      ST_READ:
        next_state = ST_EXEC;
      ST_EXEC:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // Sticky status: an event in the cycle of its clear wins
  always @*
  begin
    events = {SW{1'b0}};
    events[`AAFX_ST_ILLEGAL] = issue & (state == ST_IDLE) & ~is_abs & ~is_add;
    events[`AAFX_ST_OVF]     = exec_ok & oe_q & ovf;
    events[`AAFX_ST_ABSNEG]  = exec_ok & is_abs_q &
                               (opa == `AAFX_MOST_NEG);
    next_status = status;
    if (reg_wr && reg_addr == ADR_CLEAR)
      next_status = status & ~reg_wdata[SW-1:0];
    next_status = next_status | events;
  end

  // Control state and the held instruction word
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state   <= ST_IDLE;
      instr_q <= 32'h00000000;
    end
    else
    begin
      state <= next_state;
      if (state == ST_IDLE && issue)
        instr_q <= instr;
    end
  end

  // Software settings; the mode bit only gates decode of abs words
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      legacy_arch <= 1'b1;
      irq_enable  <= {SW{1'b0}};
      gpr_index   <= 5'h00;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ADR_CTRL:   legacy_arch <= reg_wdata[0];
        ADR_ENABLE: irq_enable  <= reg_wdata[SW-1:0];
        ADR_GPR_IX: gpr_index   <= reg_wdata[4:0];
        default:    ;
      endcase
    end
  end

  // Sticky status; irq follows the status value it will show next
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      status  <= {SW{1'b0}};
      irq     <= 1'b0;
      illegal <= 1'b0;
    end
    else
    begin
      status  <= next_status;
      irq     <= |(next_status & irq_enable);
      illegal <= events[`AAFX_ST_ILLEGAL];
    end
  end

  // Write-back record: done pulses once, register and value stand
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      done    <= 1'b0;
      wb_reg  <= 5'h00;
      wb_data <= 32'h00000000;
    end
    else
    begin
      done <= exec_ok;
      if (exec_ok)
      begin
        wb_reg  <= dest_q;
        wb_data <= result;
      end
    end
  end

  // Exception bits; a software load in the execute cycle is dropped
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      {summary_flag, overflow_flag, carry_flag} <= `AAFX_XER_RESET;
    else if (exec_ok)
    begin
      // Carry is never written by either operation
      carry_flag <= carry_flag;
      if (oe_q)
      begin
        overflow_flag <= ovf;
        summary_flag  <= next_so;
      end
    end
    else if (reg_wr && reg_addr == ADR_XER && state != ST_EXEC)
      {summary_flag, overflow_flag, carry_flag} <= reg_wdata[2:0];
  end

  // Condition field 0 moves only for recording forms
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      {neg_result, pos_result, zero_result, cr0_summary} <= `AAFX_CR0_RESET;
    else if (exec_ok && rc_q)
    begin
      neg_result  <= result[WIDTH-1];
      pos_result  <= ~result[WIDTH-1] & (|result);
      zero_result <= ~(|result);
      cr0_summary <= oe_q ? next_so : summary_flag;
    end
  end

  // Read data stand from the cycle after the strobe; general registers
  // are preload-only, which saves a third read port
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        ADR_CTRL:   reg_rdata <= {31'h0, legacy_arch};
        ADR_XER:
          reg_rdata <= {29'h0, summary_flag, overflow_flag, carry_flag};
        ADR_CR0:
          reg_rdata <= {28'h0, neg_result, pos_result, zero_result,
                        cr0_summary};
        ADR_STATUS: reg_rdata <= {{(32-SW){1'b0}}, status};
        ADR_ENABLE: reg_rdata <= {{(32-SW){1'b0}}, irq_enable};
        ADR_RESULT: reg_rdata <= wb_data;
        ADR_GPR_IX: reg_rdata <= {27'h0, gpr_index};
        default:    reg_rdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// ==== verification/aafx_checker.sv ====
// Checker for the abs/add slice: latency, hold and flag relations
// Bound to the slice top; sees its ports only
`timescale 1ns/1ps
module aafx_checker
(
  // Clock and reset
  input wire        sys_clk,
  input wire        nrst,
  // Requests
  input wire        issue,
  input wire [3:0]  reg_addr,
  input wire        reg_wr,
  // Results
  input wire        done,
  input wire        illegal,
  input wire [31:0] wb_data,
  input wire        carry_flag,
  input wire        summary_flag,
  input wire        neg_result,
  input wire        pos_result,
  input wire        zero_result,
  input wire        cr0_summary
);
  wire xer_wr;
  assign xer_wr = reg_wr && reg_addr == 4'h1;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  property p_carry_hold;
    $changed(carry_flag) |-> $past(xer_wr);
  endproperty
  a_carry_hold: assert property (p_carry_hold)
    else $error("carry moved without a register write");
  property p_done_lat;
    done |-> $past(issue, 3);
  endproperty
  a_done_lat: assert property (p_done_lat)
    else $error("done not three cycles after issue");
  property p_illegal_lat;
    illegal |-> $past(issue) || $past(issue, 2);
  endproperty
  a_illegal_lat: assert property (p_illegal_lat)
    else $error("illegal without a recent issue");
  property p_excl;
    !(done && illegal);
  endproperty
  a_excl: assert property (p_excl)
    else $error("done and illegal together");
  property p_wb_stable;
    $changed(wb_data) |-> done;
  endproperty
  a_wb_stable: assert property (p_wb_stable)
    else $error("result moved without done");
  property p_so_sticky;
    $fell(summary_flag) |-> $past(xer_wr);
  endproperty
  a_so_sticky: assert property (p_so_sticky)
    else $error("summary fell without a register write");
  property p_cr_onehot;
    neg_result || pos_result || zero_result
      |-> $onehot({neg_result, pos_result, zero_result});
  endproperty
  a_cr_onehot: assert property (p_cr_onehot)
    else $error("sign bits not one-hot");
  property p_cr0_so;
    $changed(cr0_summary) |-> done && cr0_summary == summary_flag;
  endproperty
  a_cr0_so: assert property (p_cr0_so)
    else $error("field summary not copied on done");
  c_done: cover property (done && neg_result);
  c_illegal: cover property (illegal);
  c_so_clear: cover property ($fell(summary_flag));
endmodule

bind aafx_unit aafx_checker u_chk
(
  .sys_clk      (sys_clk),
  .nrst         (nrst),
  .issue        (issue),
  .reg_addr     (reg_addr),
  .reg_wr       (reg_wr),
  .done         (done),
  .illegal      (illegal),
  .wb_data      (wb_data),
  .carry_flag   (carry_flag),
  .summary_flag (summary_flag),
  .neg_result   (neg_result),
  .pos_result   (pos_result),
  .zero_result  (zero_result),
  .cr0_summary  (cr0_summary)
);

// ==== verification/aafx_issue_model.sv ====
// Decode-side model: hands one instruction word per request to the slice
// Word is inverted every cycle while not issuing, so stale fields look valid only every other cycle
`timescale 1ns/1ps
module aafx_issue_model
(
  // Clock and bench request
  input  wire        sys_clk,
  input  wire        req,
  input  wire [31:0] word,
  // To the slice
  output reg         issue,
  output reg  [31:0] instr
);
  initial
  begin
    issue = 1'b0;
    instr = 32'h0;
  end
  always @(posedge sys_clk)
  begin
    issue <= req;
    instr <= req ? word : ~instr;
  end
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the abs/add slice
// Instructions via the issue model, registers via the strobe port
`timescale 1ns/1ps
`include "aafx_defines.vh"
module testbench;
  logic        sys_clk, nrst, req, issue, reg_wr, reg_rd, done, illegal;
  logic        carry_flag, overflow_flag, summary_flag, irq, cr0_summary;
  logic        neg_result, pos_result, zero_result;
  logic        so, ov, ca, ng, ps, zr, cs, legacy;
  logic [3:0]  reg_addr;
  logic [4:0]  wb_reg, lr;
  logic [31:0] word, instr, reg_wdata, reg_rdata, wb_data, ld, w;
  logic [31:0] general_register [32];
  logic [44:0] q [$];
  int          miscompares, n_tests, i;

  aafx_issue_model u_iss (.sys_clk(sys_clk), .req(req), .word(word),
    .issue(issue), .instr(instr));
  aafx_unit dut (.sys_clk(sys_clk), .nrst(nrst), .issue(issue),
    .instr(instr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .done(done),
    .illegal(illegal), .wb_reg(wb_reg), .wb_data(wb_data),
    .carry_flag(carry_flag), .overflow_flag(overflow_flag),
    .summary_flag(summary_flag), .neg_result(neg_result),
    .pos_result(pos_result), .zero_result(zero_result),
    .cr0_summary(cr0_summary), .irq(irq));

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [44:0] e, g);
    n_tests++;
    if (e !== g)
    begin
      miscompares++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic report_and_stop;
    $display("Compares %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand from the cycle after the strobe until the next read strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    chk({13'h0, e}, {13'h0, reg_rdata});
  endtask

  function automatic logic [31:0] mk(input logic [8:0] x,
                                     input logic [14:0] dab,
                                     input logic [1:0] orc);
    return {`AAFX_PRIMARY_OP, dab, orc[1], x, orc[0]};
  endfunction

  // Expected outcome noted first; spacing keeps the slice idle at issue
  task automatic op(input logic [31:0] v);
    logic [31:0] a, b, r;
    logic        o, add, bad;
    a = general_register[v[20:16]];
    b = general_register[v[15:11]];
    add = v[9:1] == `AAFX_XOP_ADD;
    bad = v[31:26] != `AAFX_PRIMARY_OP ||
          !(add || (v[9:1] == `AAFX_XOP_ABS && legacy));
    r = add ? a + b : (a[31] ? -a : a);
    o = add ? a[31] == b[31] && r[31] != a[31] : a == `AAFX_MOST_NEG;
    if (!bad)
    begin
      if (v[10])
      begin
        ov = o;
        so = so | o;
      end
      if (v[0])
        {ng, ps, zr, cs} = {r[31], !r[31] && r != 0, r == 0, so};
      lr = v[25:21];
      ld = r;
      general_register[lr] = r;
    end
    q.push_back({bad, lr, ld, so, ov, ca, ng, ps, zr, cs});
    @(posedge sys_clk);
    req  <= 1'b1;
    word <= v;
    @(posedge sys_clk);
    req <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk)
    if (done === 1'b1 || illegal === 1'b1)
      chk(q.pop_front(), {illegal, wb_reg, wb_data,
        summary_flag, overflow_flag, carry_flag, neg_result, pos_result,
        zero_result, cr0_summary});

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    report_and_stop;
  end

  initial
  begin
    {nrst, req, word, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {so, ov, ca, ng, ps, zr, cs, lr, ld} = '0;
    legacy = 1'b1;
    void'($urandom(32'hbaf07832));
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(4'h0, 32'h1);
    rd(4'h9, 32'h0);
    wr(4'h1, 32'h1);
    ca = 1'b1;
    wr(4'h5, 32'h4);
    for (i = 1; i < 8; i++)
    begin
      w = i < 5 ? $urandom() : i == 5 ? `AAFX_MOST_NEG :
          i == 6 ? 32'h7fffffff : 32'hffffffff;
      wr(4'h7, 32'(i));
      wr(4'h8, w);
      general_register[i] = w;
    end
    for (i = 0; i < 8; i++)
      op(mk(`AAFX_XOP_ADD, {5'(8 + i), i[2] ? 5'd6 : 5'd1, 5'd6},
        i[1:0]));
    repeat (6) @(posedge sys_clk);
    chk(45'h0, {44'h0, irq});
    $display("Test add forms finished");
    for (i = 1; i < 8; i++)
      op(mk(`AAFX_XOP_ABS, {5'(16 + i), 5'(i), 5'd0}, 2'(i + 1)));
    repeat (6) @(posedge sys_clk);
    chk(45'h1, {44'h0, irq});
    rd(4'h3, 32'h6);
    rd(4'h1, {29'h0, so, ov, ca});
    wr(4'h4, 32'h7);
    repeat (3) @(posedge sys_clk);
    chk(45'h0, {44'h0, irq});
    $display("Test abs and interrupt finished");
    wr(4'h0, 32'h0);
    legacy = 1'b0;
    op(mk(`AAFX_XOP_ABS, {5'd20, 5'd1, 5'd0}, 2'b11));
    w = mk(`AAFX_XOP_ADD, {5'd20, 5'd1, 5'd2}, 2'b11);
    w[31:26] = 6'h1e;
    op(w);
    wr(4'h1, 32'h0);
    {so, ov, ca} = 3'h0;
    op(mk(`AAFX_XOP_ADD, {5'd21, 5'd7, 5'd7}, 2'b11));
    repeat (8) @(posedge sys_clk);
    chk(45'h0, 45'(q.size()));
    $display("Test refusals finished");
    report_and_stop;
  end
endmodule
